// File: hw/register_space_decoder_arbiter.sv
// Shared register space front end: decode, aliasing, arbitration, irq steering.
// Assumes both masters and all modules run on mclk; masters hold req until ack.
//
// Behaviour
// - One space of exactly 1024 byte locations
// - Controller sees 1024 addresses from 0xA000
// - Four serial pages; bytes 0-15 global
// - Absolute address is base plus offset
// - Access manager at 0x10, sixteen bytes
// - Power controller 0x20, clock 0x40
// - Linear regulators at 0x60, 32 bytes
// - Switching regulators at 0x80, 16 bytes
// - Charger 0x90, timers 0xA0, 0xB0 reserved
// - Touch converter unit at 0xC0, 64 bytes
// - Audio at page 1, 240 bytes
// - Amplifier digital page 2; page 3 reserved
// - Controller reaches every register; serial misses audio and amp bytes 0-15
// - Hardware arbitration, no corrupted accesses
// - Each interrupt steered to either master
// - External-only mode drives interrupt pin
// - Serial path works without the controller
`timescale 1ns/10ps
`default_nettype none
`include "regspace_consts.svh"
module register_space_decoder_arbiter
  import regspace_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire ser_req_s serReq,
  output bus_ans_s serAns_r,
  input wire mcu_req_s mcuReq,
  output bus_ans_s mcuAns_r,
  input wire logic mcuPowered,
  input wire logic extOnly,
  output mod_req_s modReq_r,
  output logic [`RS_MOD_COUNT-1:0] modSel_r,
  input wire logic [`RS_MOD_COUNT-1:0][7:0] modRdata,
  input wire logic [`RS_IRQ_COUNT-1:0] irqIn,
  output logic irqExtPin_r,
  output logic irqMcu_r
);

  // Which module owns a space index; gaps fall to MOD_NONE
  function automatic module_id_e moduleOf(input logic [9:0] idx);
    module_id_e id;
    id = MOD_NONE;
    case (idx[9:8])
      2'b00: begin
        case (idx[7:4])
          4'h0: id = MOD_GLOBAL;
          4'h1: id = MOD_ACCESS_MANAGER;
          4'h2, 4'h3: id = MOD_POWER_CONTROLLER;
          4'h4, 4'h5: id = MOD_RTC;
          4'h6, 4'h7: id = MOD_LDO;
          4'h8: id = MOD_SWITCHING_REGULATORS;
          4'h9: id = MOD_CHARGER;
          4'hA: id = MOD_GENERAL_TIMERS;
          4'hB: id = MOD_NONE;
          default: id = MOD_TOUCH_CONVERTER_UNIT;
        endcase
      end
      2'b01: begin
        // Top sixteen bytes of the page lie past the module
        id = (idx[7:0] < `RS_SIZE_AUDIO) ? MOD_AUDIO : MOD_NONE;
      end
      2'b10: begin
        id = (idx[7:0] < `RS_SIZE_AMP) ? MOD_SPEAKER_AMP_DIGITAL : MOD_NONE;
      end
      default: id = MOD_NONE;
    endcase
    return id;
  endfunction : moduleOf

  // Base index of a module, so that offset = index - base
  function automatic logic [9:0] baseOf(input module_id_e id);
    logic [9:0] b;
    b = `RS_BASE_GLOBAL;
    case (id)
      MOD_ACCESS_MANAGER: b = `RS_BASE_ACCESS;
      MOD_POWER_CONTROLLER: b = `RS_BASE_POWER;
      MOD_RTC: b = `RS_BASE_RTC;
      MOD_LDO: b = `RS_BASE_LDO;
      MOD_SWITCHING_REGULATORS: b = `RS_BASE_SWREG;
      MOD_CHARGER: b = `RS_BASE_CHARGER;
      MOD_GENERAL_TIMERS: b = `RS_BASE_TIMERS;
      MOD_TOUCH_CONVERTER_UNIT: b = `RS_BASE_TOUCH;
      MOD_AUDIO: b = `RS_BASE_AUDIO;
      MOD_SPEAKER_AMP_DIGITAL: b = `RS_BASE_AMP;
      default: b = `RS_BASE_GLOBAL;
    endcase
    return b;
  endfunction : baseOf

  access_state_e state_r; // Sequencer state
  logic [1:0] pageSel_r; // Serial page select
  logic [15:0] route_r; // Per-interrupt steering, 1 sends it out
  logic [9:0] curIdx_r; // Index of the access in flight
  logic curWrite_r; // Access in flight is a write
  logic [7:0] curWdata_r; // Write data in flight
  logic curSer_r; // Access in flight belongs to the serial side
  logic curUnmapped_r; // Controller address outside the window
  module_id_e curMod_r; // Decoded target of the access in flight
  logic [9:0] serIdx; // Serial request after page mapping
  logic [15:0] mcuDelta; // Controller address less the window base
  logic mcuInWindow; // Controller address falls in the window
  logic serWant; // Serial request seen
  logic mcuWant; // Controller request seen
  logic take; // An access is accepted this cycle
  logic grantSer; // Arbiter picks the serial side
  logic [9:0] nextIdx; // Index of the access being accepted
  logic nextUnmapped; // That access lies outside the window
  module_id_e nextMod; // Target of the access being accepted
  logic curInternal; // In-flight access hits a global kept here
  logic [7:0] readValue; // Data returned for the access in flight

  // Paging of the serial side
  serial_page_map pageMap (
    .page(pageSel_r),
    .offset(serReq.offset),
    .index(serIdx)
  );

  // A powered-down controller cannot block the serial side
  assign serWant = serReq.req;
  assign mcuWant = mcuReq.req && mcuPowered;
  assign take = (state_r == ST_IDLE) && (serWant || mcuWant);

  // Contention goes to the arbiter; one access at a time
  access_arbiter arbiter (
    .mclk(mclk),
    .reset(reset),
    .serWant(serWant),
    .mcuWant(mcuWant),
    .take(take),
    .grantSer(grantSer)
  );

  // Linear controller window of the whole space
  assign mcuDelta = mcuReq.addr - `RS_MCU_BASE;
  assign mcuInWindow = (mcuReq.addr >= `RS_MCU_BASE) && (mcuReq.addr <= `RS_MCU_LAST);

  // Select the accepted master's index
  always_comb begin
    if (grantSer) begin
      nextIdx = serIdx;
      nextUnmapped = 1'b0;
    end else begin
      nextIdx = mcuDelta[9:0];
      nextUnmapped = !mcuInWindow;
    end
    nextMod = nextUnmapped ? MOD_NONE : moduleOf(nextIdx);
  end

  // Sequencer: accept, strobe one module, answer, then rest a cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_ACCESS;
          end
        end
        ST_ACCESS: state_r <= ST_DONE;
        // Rest cycle lets the master drop its request after ack
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Capture the accepted access so later requests cannot disturb it
  always_ff @(posedge mclk) begin
    if (reset) begin
      curIdx_r <= 10'h000;
      curWrite_r <= 1'b0;
      curWdata_r <= 8'h00;
      curSer_r <= 1'b0;
      curUnmapped_r <= 1'b0;
      curMod_r <= MOD_NONE;
    end else if (take) begin
      curIdx_r <= nextIdx;
      curWrite_r <= grantSer ? serReq.write : mcuReq.write;
      curWdata_r <= grantSer ? serReq.wdata : mcuReq.wdata;
      curSer_r <= grantSer;
      curUnmapped_r <= nextUnmapped;
      curMod_r <= nextMod;
    end
  end

  // Module strobe for exactly the access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      modSel_r <= '0;
      modReq_r <= '0;
    end else if (take) begin
      modSel_r <= '0;
      // Reserved space and globals kept here never reach a module
      if (nextMod != MOD_NONE && nextIdx[9:2] != 8'h00) begin
        modSel_r[nextMod] <= 1'b1;
      end
      modReq_r.write <= grantSer ? serReq.write : mcuReq.write;
      modReq_r.wdata <= grantSer ? serReq.wdata : mcuReq.wdata;
      modReq_r.offset <= 8'(nextIdx - baseOf(nextMod));
    end else begin
      modSel_r <= '0;
    end
  end

  // Global bytes 0 to 3 are served inside this block
  assign curInternal = (curIdx_r[9:2] == 8'h00) && !curUnmapped_r;

  // Read data: internal globals, the module, or zero for gaps
  always_comb begin
    readValue = 8'h00;
    if (curInternal) begin
      if (curIdx_r == `RS_PAGESEL_IDX) begin
        readValue = {6'h00, pageSel_r};
      end else if (curIdx_r == `RS_ROUTE_LO_IDX) begin
        readValue = route_r[7:0];
      end else if (curIdx_r == `RS_ROUTE_HI_IDX) begin
        readValue = route_r[15:8];
      end
    end else if (curMod_r != MOD_NONE) begin
      readValue = modRdata[curMod_r];
    end else begin
      readValue = 8'h00;
    end
  end

  // Writes to the internal globals land in the access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pageSel_r <= `RS_PAGESEL_RESET;
      route_r <= `RS_ROUTE_RESET;
    end else if (state_r == ST_ACCESS && curWrite_r && curInternal) begin
      if (curIdx_r == `RS_PAGESEL_IDX) begin
        pageSel_r <= curWdata_r[1:0];
      end
      if (curIdx_r == `RS_ROUTE_LO_IDX) begin
        route_r[7:0] <= curWdata_r;
      end
      if (curIdx_r == `RS_ROUTE_HI_IDX) begin
        route_r[15:8] <= curWdata_r;
      end
    end
  end

  // Answer the owner of the access; the other master keeps waiting
  always_ff @(posedge mclk) begin
    if (reset) begin
      serAns_r <= '0;
      mcuAns_r <= '0;
    end else if (state_r == ST_ACCESS) begin
      serAns_r.ack <= curSer_r;
      mcuAns_r.ack <= !curSer_r;
      if (curSer_r) begin
        serAns_r.rdata <= curWrite_r ? 8'h00 : readValue;
      end else begin
        mcuAns_r.rdata <= curWrite_r ? 8'h00 : readValue;
      end
    end else begin
      serAns_r.ack <= 1'b0;
      mcuAns_r.ack <= 1'b0;
    end
  end

  // Steering of levels; external-only mode sends everything to the pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqExtPin_r <= 1'b0;
      irqMcu_r <= 1'b0;
    end else begin
      irqExtPin_r <= |(irqIn & (route_r | {16{extOnly}}));
      irqMcu_r <= !extOnly && |(irqIn & ~route_r);
    end
  end

  // Accesses strobe at most one module
  one_target_a: assert property (@(posedge mclk) disable iff (reset)
    $onehot0(modSel_r)) else $error("more than one module strobed");

  // Only one master is answered at a time
  single_answer_a: assert property (@(posedge mclk) disable iff (reset)
    !(serAns_r.ack && mcuAns_r.ack)) else $error("both masters answered");

  // Every accepted access is answered two cycles later
  answer_latency_a: assert property (@(posedge mclk) disable iff (reset)
    take |-> ##2 (serAns_r.ack || mcuAns_r.ack)) else $error("answer not after two cycles");

  // Controller window is linear from the base
  mcu_window_a: assert property (@(posedge mclk) disable iff (reset)
    (take && !grantSer && mcuInWindow) |=> ({6'h00, curIdx_r} == $past(mcuDelta)))
    else $error("controller index wrong");

  // Low serial offsets alias the global block
  page_alias_a: assert property (@(posedge mclk) disable iff (reset)
    (take && grantSer && serReq.offset < 8'h10) |=> curIdx_r[9:4] == 6'h00)
    else $error("global alias broken");

  // Upper serial offsets follow the page select
  serial_page_a: assert property (@(posedge mclk) disable iff (reset)
    (take && grantSer && serReq.offset >= 8'h10)
    |=> curIdx_r == {$past(pageSel_r), $past(serReq.offset)})
    else $error("serial page mapping wrong");

  // Unmapped controller reads return zero
  gap_read_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ST_ACCESS && !curSer_r && curUnmapped_r) |=> mcuAns_r.rdata == 8'h00)
    else $error("unmapped read not zero");

  // Audio strobes stay inside page one below 0xF0
  audio_range_a: assert property (@(posedge mclk) disable iff (reset)
    modSel_r[MOD_AUDIO] |-> (curIdx_r[9:8] == 2'b01 && curIdx_r[7:0] < 8'hF0))
    else $error("audio decode out of range");

  // Serial side proceeds while the controller is off
  serial_alone_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ST_IDLE && serWant && !mcuPowered) |=> state_r == ST_ACCESS)
    else $error("serial stalled without controller");

  // External-only mode raises the pin for any source
  ext_irq_a: assert property (@(posedge mclk) disable iff (reset)
    (extOnly && |irqIn) |=> irqExtPin_r && !irqMcu_r) else $error("interrupt pin not raised");

  // Main scenarios
  contention_c: cover property (@(posedge mclk) disable iff (reset)
    state_r == ST_IDLE && serWant && mcuWant);
  page_write_c: cover property (@(posedge mclk) disable iff (reset)
    state_r == ST_ACCESS && curInternal && curWrite_r && curIdx_r == `RS_PAGESEL_IDX);
  amp_access_c: cover property (@(posedge mclk) disable iff (reset)
    modSel_r[MOD_SPEAKER_AMP_DIGITAL]);
  gap_access_c: cover property (@(posedge mclk) disable iff (reset)
    state_r == ST_ACCESS && curMod_r == MOD_NONE);

endmodule : register_space_decoder_arbiter
`default_nettype wire

// File: common/regspace_consts.svh
// Constants of the shared register space: bases, sizes, internal globals.
// Assumes a byte-wide space of 1024 locations; included by package and top.
`ifndef REGSPACE_CONSTS_SVH
`define REGSPACE_CONSTS_SVH

// Space geometry
`define RS_SPACE_BYTES 1024
`define RS_IDX_W 10
`define RS_PAGE_BYTES 256
`define RS_GLOBAL_BYTES 16
`define RS_MCU_BASE 16'hA000
`define RS_MCU_LAST 16'hA3FF

// Module base indices within the space
`define RS_BASE_GLOBAL 10'h000
`define RS_BASE_ACCESS 10'h010
`define RS_BASE_POWER 10'h020
`define RS_BASE_RTC 10'h040
`define RS_BASE_LDO 10'h060
`define RS_BASE_SWREG 10'h080
`define RS_BASE_CHARGER 10'h090
`define RS_BASE_TIMERS 10'h0A0
`define RS_BASE_RSV0 10'h0B0
`define RS_BASE_TOUCH 10'h0C0
`define RS_BASE_AUDIO 10'h100
`define RS_BASE_AMP 10'h200
`define RS_BASE_RSV3 10'h300

// Module sizes in bytes
`define RS_SIZE_AUDIO 10'h0F0
`define RS_SIZE_AMP 10'h0F0

// Counts
`define RS_MOD_COUNT 11
`define RS_IRQ_COUNT 16

// Global bytes served inside this block
`define RS_PAGESEL_IDX 10'h000
`define RS_ROUTE_LO_IDX 10'h002
`define RS_ROUTE_HI_IDX 10'h003
`define RS_PAGESEL_RESET 2'h0
`define RS_ROUTE_RESET 16'h0000
`endif

// File: common/regspace_pkg.sv
// Types of the register space front end: requests, answers, module ids.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
`include "regspace_consts.svh"
package regspace_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_DONE = 3'b100
  } access_state_e;

  // Target modules; MOD_NONE marks reserved space
  typedef enum logic [3:0] {
    MOD_GLOBAL = 4'h0, MOD_ACCESS_MANAGER = 4'h1, MOD_POWER_CONTROLLER = 4'h2,
    MOD_RTC = 4'h3, MOD_LDO = 4'h4, MOD_SWITCHING_REGULATORS = 4'h5,
    MOD_CHARGER = 4'h6, MOD_GENERAL_TIMERS = 4'h7, MOD_TOUCH_CONVERTER_UNIT = 4'h8,
    MOD_AUDIO = 4'h9, MOD_SPEAKER_AMP_DIGITAL = 4'hA, MOD_NONE = 4'hF
  } module_id_e;

  // Serial side request: page-relative byte offset
  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] offset;
    logic [7:0] wdata;
  } ser_req_s;

  // Microcontroller side request: linear address
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mcu_req_s;

  // Answer to either master
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } bus_ans_s;

  // Access issued to the selected module
  typedef struct packed {
    logic write;
    logic [7:0] offset;
    logic [7:0] wdata;
  } mod_req_s;
endpackage : regspace_pkg
`default_nettype wire

// File: hw/serial_page_map.sv
// Maps a serial page and byte offset onto the linear space index.
// Assumes page select is held by the caller.
`timescale 1ns/10ps
`default_nettype none
module serial_page_map (
  input wire logic [1:0] page,
  input wire logic [7:0] offset,
  output logic [9:0] index
);
  // Low sixteen bytes of every page alias the global block
  always_comb begin
    if (offset < 8'h10) begin
      index = {2'b00, offset};
    end else begin
      index = {page, offset};
    end
  end
endmodule : serial_page_map
`default_nettype wire

// File: hw/access_arbiter.sv
// Two-master round-robin arbiter for the shared register space.
// Assumes requests hold until answered; grant is sampled when take is high.
`timescale 1ns/10ps
`default_nettype none
module access_arbiter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic serWant,
  input wire logic mcuWant,
  input wire logic take,
  output logic grantSer
);
  logic lastSer_r; // Serial side got the last taken access

  // Alternate on contention so neither master starves
  always_comb begin
    if (serWant && mcuWant) begin
      grantSer = !lastSer_r;
    end else begin
      grantSer = serWant;
    end
  end

  // Remember the winner of each taken access
  always_ff @(posedge mclk) begin
    if (reset) begin
      lastSer_r <= 1'b0;
    end else if (take) begin
      lastSer_r <= grantSer;
    end
  end
endmodule : access_arbiter
`default_nettype wire

// File: verification/serial_master_model.sv
// Partner model: the external processor acting as serial master, byte accesses.
// Assumes the block answers with a one-cycle ack and holds rdata after it.
`timescale 1ns/10ps
`default_nettype none
module serial_master_model
  import regspace_pkg::*;
(
  input wire logic mclk,
  output var ser_req_s serReq,
  input wire bus_ans_s serAns
);
  // Idle request at time zero
  initial serReq = '0;

  // One byte access: raised after an edge, held until the edge that sees ack
  // Partly reserved registers are written by the caller as read-modify-write
  task automatic xfer(input logic wr, input logic [7:0] off, input logic [7:0] wd,
    output logic [7:0] rd, output int edges);
    edges = 0;
    rd = 8'h00;
    @(posedge mclk);
    serReq <= '{req: 1'b1, write: wr, offset: off, wdata: wd};
    // Bounded wait; zero edges tells the caller that no ack came
    for (int n = 1; n <= 20; n++) begin
      @(posedge mclk);
      if (serAns.ack === 1'b1) begin
        rd = serAns.rdata;
        edges = n;
        break;
      end
    end
    // Released fields show the inverse, so a stale value is never mistaken
    serReq <= '{req: 1'b0, write: ~wr, offset: ~off, wdata: ~wd};
  endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// File: verification/test_register_space_decoder_arbiter.sv
// Testbench: both masters, a module-side memory and the interrupt steering.
// Assumes the package and constants header are on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "regspace_consts.svh"
module test_register_space_decoder_arbiter
  import regspace_pkg::*;
;
  logic mclk, reset, mcuPowered, extOnly, irqExtPin, irqMcu;
  ser_req_s serReq; // Driven by the partner
  bus_ans_s serAns, mcuAns;
  mcu_req_s mcuReq; // Driven by the bench as controller
  mod_req_s modReq;
  logic [`RS_MOD_COUNT-1:0] modSel, selSeen;
  logic [`RS_MOD_COUNT-1:0][7:0] modRdata;
  logic [`RS_IRQ_COUNT-1:0] irqIn;
  logic [7:0] mem [`RS_MOD_COUNT][256]; // Module register contents
  logic [7:0] offSeen;
  int fails, checked, strobes;
  // Module bases and sizes, module id is the index plus one
  localparam logic [9:0] BASES [10] = '{10'h010, 10'h020, 10'h040, 10'h060, 10'h080,
    10'h090, 10'h0A0, 10'h0C0, 10'h100, 10'h200};
  localparam logic [9:0] SIZES [10] = '{10'h010, 10'h020, 10'h020, 10'h020, 10'h010,
    10'h010, 10'h010, 10'h040, 10'h0F0, 10'h0F0};

  register_space_decoder_arbiter DUT (.mclk(mclk), .reset(reset), .serReq(serReq),
    .serAns_r(serAns), .mcuReq(mcuReq), .mcuAns_r(mcuAns), .mcuPowered(mcuPowered),
    .extOnly(extOnly), .modReq_r(modReq), .modSel_r(modSel), .modRdata(modRdata),
    .irqIn(irqIn), .irqExtPin_r(irqExtPin), .irqMcu_r(irqMcu));
  serial_master_model PARTNER (.mclk(mclk), .serReq(serReq), .serAns(serAns));

  // Clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Modules: store writes on their strobe, remember the last strobe seen
  always @(posedge mclk) begin
    if (|modSel) begin
      strobes <= strobes + 1;
      selSeen <= modSel;
      offSeen <= modReq.offset;
    end
    for (int i = 0; i < `RS_MOD_COUNT; i++) begin
      if (modSel[i] && modReq.write) mem[i][modReq.offset] <= modReq.wdata;
    end
  end

  // Read data is combinational from the offset on the module port
  always_comb begin
    for (int i = 0; i < `RS_MOD_COUNT; i++) modRdata[i] = mem[i][modReq.offset];
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Missing ack ends the run; a nonzero exp also checks the answer latency
  task automatic done(input int e, input int exp);
    if (e == 0) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, 0, exp);
      close_out();
    end else if (exp != 0) begin
      chk(32'(e), 32'(exp));
    end
  endtask : done

  task automatic sx(input logic wr, input logic [7:0] off, input logic [7:0] wd,
    output logic [7:0] rd, input int exp, output int e);
    PARTNER.xfer(wr, off, wd, rd, e);
    done(e, exp);
  endtask : sx

  // Controller access, same handshake as the serial partner
  task automatic mx(input logic wr, input logic [15:0] a, input logic [7:0] wd,
    output logic [7:0] rd, input int exp, output int e);
    e = 0;
    rd = 8'h00;
    @(posedge mclk);
    mcuReq <= '{req: 1'b1, write: wr, addr: a, wdata: wd};
    for (int n = 1; n <= 20; n++) begin
      @(posedge mclk);
      if (mcuAns.ack === 1'b1) begin
        rd = mcuAns.rdata;
        e = n;
        break;
      end
    end
    mcuReq <= '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
    done(e, exp);
  endtask : mx

  // Every module above the globals, first and last byte, written linearly and read back paged, or linearly where the byte aliases the globals
  task automatic test_decode;
    logic [9:0] idx;
    logic [7:0] rd, v;
    int e;
    for (int m = 0; m < 10; m++) begin
      for (int k = 0; k < 2; k++) begin
        idx = BASES[m] + ((k == 1) ? SIZES[m] - 10'h001 : 10'h000);
        v = 8'(8'h30 + m * 2 + k);
        mx(1'b1, 16'hA000 + {6'h00, idx}, v, rd, 3, e);
        chk(32'(selSeen), 32'(11'h001 << (m + 1)));
        chk(32'(offSeen), 32'(idx - BASES[m]));
        sx(1'b1, 8'h00, {6'h00, idx[9:8]}, rd, 3, e);
        sx(1'b0, idx[7:0], 8'h00, rd, 3, e);
        if (idx[7:0] < 8'h10) begin
          // Low bytes of a page alias the globals: byte 0 reads the page select
          chk(32'(rd), 32'(idx[9:8]));
          mx(1'b0, 16'hA000 + {6'h00, idx}, 8'h00, rd, 3, e);
        end
        chk(32'(rd), 32'(v));
      end
    end
  endtask : test_decode

  // Reserved and outside addresses: read zero and never strobe a module
  task automatic test_reserved;
    logic [15:0] adr [9] = '{16'hA001, 16'hA0B0, 16'hA0BF, 16'hA1F0, 16'hA2FF,
      16'hA300, 16'hA3FF, 16'hA400, 16'h9FFF};
    logic [7:0] rd;
    int e, s;
    s = strobes;
    for (int i = 0; i < 9; i++) begin
      // Reserved bytes inside the space are only read; writes go outside it
      mx(adr[i][15:10] != 6'h28, adr[i], 8'hFF, rd, 3, e);
      mx(1'b0, adr[i], 8'h00, rd, 3, e);
      chk(32'(rd), 32'h0000_0000);
    end
    chk(32'(strobes), 32'(s));
  endtask : test_reserved

  // Globals alias into page 3, the rest of page 3 is reserved
  task automatic test_alias;
    logic [7:0] rd;
    int e, s;
    // Page select has reserved upper bits, so it is changed read-modify-write
    sx(1'b0, 8'h00, 8'h00, rd, 3, e);
    chk(32'(rd), 32'h0000_0002);
    sx(1'b1, 8'h00, {rd[7:2], 2'b11}, rd, 3, e);
    sx(1'b1, 8'h05, 8'h5A, rd, 3, e);
    chk(32'(selSeen), 32'h0000_0001);
    chk(32'(offSeen), 32'h0000_0005);
    mx(1'b0, 16'hA005, 8'h00, rd, 3, e);
    chk(32'(rd), 32'h0000_005A);
    s = strobes;
    sx(1'b0, 8'h10, 8'h00, rd, 3, e);
    chk(32'(rd), 32'h0000_0000);
    chk(32'(strobes), 32'(s));
    sx(1'b1, 8'h00, 8'h00, rd, 3, e);
  endtask : test_alias

  // Two contests: serial wins the first; after a lone serial access the controller wins
  task automatic test_contest;
    logic [7:0] r1, r2;
    int es, em;
    for (int t = 0; t < 2; t++) begin
      if (t == 1) begin
        // Round robin remembers the last winner, so hand the last access to serial
        sx(1'b0, 8'h21, 8'h00, r1, 3, es);
        chk(32'(r1), 32'h0000_00C0);
      end
      fork
        sx(1'b1, 8'h21, 8'(8'hC0 + t), r1, 0, es);
        mx(1'b1, 16'hA041, 8'(8'hD0 + t), r2, 0, em);
      join
      chk(32'(mem[2][1]), 32'(8'hC0 + t));
      chk(32'(mem[3][1]), 32'(8'hD0 + t));
      chk(32'((t == 0) ? es < em : em < es), 32'h0000_0001);
    end
  endtask : test_contest

  // Controller asleep: its request is never answered, serial path still works
  task automatic test_unpowered;
    logic [7:0] rd;
    int e, acks;
    acks = 0;
    @(posedge mclk);
    mcuPowered <= 1'b0;
    mcuReq <= '{req: 1'b1, write: 1'b1, addr: 16'hA062, wdata: 8'h11};
    repeat (8) begin
      @(posedge mclk);
      if (mcuAns.ack !== 1'b0) acks++;
    end
    mcuReq <= '{req: 1'b0, write: 1'b0, addr: 16'h5F9D, wdata: 8'hEE};
    chk(32'(acks), 32'h0000_0000);
    sx(1'b1, 8'h62, 8'h77, rd, 3, e);
    sx(1'b0, 8'h62, 8'h00, rd, 3, e);
    chk(32'(rd), 32'h0000_0077);
    @(posedge mclk);
    mcuPowered <= 1'b1;
  endtask : test_unpowered

  // Route 0x8001 sends sources 0 and 15 to the pin; external-only takes all
  task automatic test_irq;
    logic [17:0] tab [6] = '{{16'h0001, 2'b10}, {16'h0002, 2'b01}, {16'h8000, 2'b10},
      {16'h0000, 2'b00}, {16'h0002, 2'b10}, {16'h0000, 2'b00}};
    logic [7:0] rd;
    int e;
    mx(1'b1, 16'hA002, 8'h01, rd, 3, e);
    mx(1'b1, 16'hA003, 8'h80, rd, 3, e);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      irqIn <= tab[i][17:2];
      extOnly <= (i >= 4);
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(irqExtPin), 32'(tab[i][1]));
      chk(32'(irqMcu), 32'(tab[i][0]));
    end
  endtask : test_irq

  // Main sequence
  initial begin
    reset = 1'b1;
    mcuPowered = 1'b1;
    extOnly = 1'b0;
    irqIn = '0;
    mcuReq = '0;
    fails = 0;
    checked = 0;
    strobes = 0;
    selSeen = '0;
    offSeen = 8'h00;
    for (int i = 0; i < `RS_MOD_COUNT; i++) begin
      for (int j = 0; j < 256; j++) mem[i][j] = 8'h00;
    end
    repeat (5) @(posedge mclk);
    #1;
    chk(32'({serAns.ack, mcuAns.ack, modSel, irqExtPin, irqMcu}), 32'h0000_0000);
    @(posedge mclk);
    reset <= 1'b0;
    test_contest();
    test_decode();
    test_reserved();
    test_alias();
    test_unpowered();
    test_irq();
    close_out();
  end
endmodule : test_register_space_decoder_arbiter
`default_nettype wire
